// File: include/sovm_defs.svh
// Offsets, field positions, reset values, the options write mask and the power read mask of the options and power monitor registers
`ifndef SOVM_DEFS_SVH
`define SOVM_DEFS_SVH

`define SOVM_OFF_OPTIONS      12'h000
`define SOVM_OFF_POWER        12'h004
`define SOVM_OFF_OPTIONS_TWO  12'h008
`define SOVM_OFF_IRQ_STATUS   12'h00C
`define SOVM_OFF_IRQ_MASK     12'h010

`define SOVM_OPT_WDT_HI       7
`define SOVM_OPT_WDT_LO       6
`define SOVM_OPT_STOP         5
`define SOVM_OPT_RSVD         4
`define SOVM_OPT_PINSEL       2

`define SOVM_PWR_WFLAG        7
`define SOVM_PWR_WACK         6
`define SOVM_PWR_WIE          5
`define SOVM_PWR_DRE          4
`define SOVM_PWR_DSE          3
`define SOVM_PWR_DE           2
`define SOVM_PWR_BANDGAP_BUFFER_ENABLE         0

`define SOVM_OPT2_WDTCLK      7

`define SOVM_IRQ_WARN         0
`define SOVM_IRQ_DETECT       1
`define SOVM_IRQ_BLOCKED      2
`define SOVM_IRQ_BITS         3

`define SOVM_OPTIONS_RESET    8'hD3
`define SOVM_POWER_RESET      8'h1C
`define SOVM_OPTIONS_TWO_RST  8'h00
`define SOVM_OPTIONS_MASK     8'hF4
`define SOVM_POWER_MASK       8'hBD

`endif

// File: include/sovm_pkg.sv
// Types shared by the options and power monitor register block
package sovm_pkg;

    typedef enum logic [1:0] {
        SOVM_WRITE_OPEN   = 2'b00,
        SOVM_WRITE_LOCKED = 2'b01
    } sovm_once_e;

    typedef struct packed {
        logic [1:0] timeout_select;
        logic       clock_select;
        logic       stop_permit;
        logic       pin_select;
    } sovm_sysctl_s;

    typedef struct packed {
        logic detect_reset_req;
        logic detect_active;
        logic bandgap_buffer_enable;
        logic warning_irq;
    } sovm_pwrctl_s;

endpackage

// File: rtl/sovm_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps

module sovm_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             pclk,     // Bus clock
    input  wire logic             presetn,  // Async reset, low
    input  wire logic [WIDTH-1:0] async_in, // Level from another domain
    output logic      [WIDTH-1:0] sync_out  // Level in pclk domain
);

    logic [WIDTH-1:0] meta;

    // First stage is read only by the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // sovm_sync

// File: rtl/sovm_regs.sv
// Write-once system options and low-voltage monitor registers behind APB
//
// Behaviour
// - Options register accepts only first write after reset
// - Reserved bit 4 stores value, no effect
// - Timeout bits with clock select choose watchdog period
// - Stop without permit forces illegal-opcode reset
// - Pin select routes two-wire pins A or B
// - Warning flag sticky, shows present or past warning
// - Flag sets on warning, including right after reset
// - Acknowledge clears flag only if warning gone
// - Interrupt enable requests interrupt while flag set
// - Detect reset enable forces reset on enabled detect
// - Stop enable keeps detection alive in stop
// - Detect enable gates all detect logic
// - Bandgap buffer enable drives reference buffer
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "sovm_defs.svh"

module sovm_regs (
    input  wire logic        pclk,              // APB clock, 25 MHz
    input  wire logic        presetn,           // Async reset, low
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB access phase
    input  wire logic        pwrite,            // APB write
    input  wire logic [11:0] paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    input  wire logic [3:0]  pstrb,             // APB byte strobes
    output logic             pready,            // APB ready
    output logic      [31:0] prdata,            // APB read data
    output logic             pslverr,           // APB error, unmapped
    input  wire logic        warning_level,     // Async supply below warning point
    input  wire logic        detect_level,      // Async supply below detect point
    input  wire logic        stop_request,      // CPU executes stop
    input  wire logic        in_stop,           // Device is in stop mode
    output logic             stop_enter,        // Stop may proceed
    output logic             illegal_op_reset,  // Forced reset, stop not permitted
    output logic             detect_reset,      // Reset from low-voltage detect
    output logic             detect_on,         // Detect circuit powered
    output logic             bandgap_buffer_enable, // Reference buffer on
    output logic [1:0]       watchdog_timeout_select, // Watchdog period select
    output logic             watchdog_clock_select,   // Watchdog clock select
    output logic             two_wire_pin_select,     // 0 port A, 1 port B
    output logic             sda_on_port_a_pin_2,     // Data routed to port A pin 2
    output logic             scl_on_port_a_pin_3,     // Clock routed to port A pin 3
    output logic             sda_on_port_b_pin_6,     // Data routed to port B pin 6
    output logic             scl_on_port_b_pin_7,     // Clock routed to port B pin 7
    output logic             warning_irq,       // Warning interrupt request
    output logic             irq                // Summary interrupt, level
);

    // Register storage
    logic [7:0]       options;
    logic [7:0]       power;
    logic [7:0]       options_two;
    logic [`SOVM_IRQ_BITS-1:0] irq_status;
    logic [`SOVM_IRQ_BITS-1:0] irq_mask;
    sovm_pkg::sovm_once_e options_state;
    sovm_pkg::sovm_once_e power_state;
    logic             low_voltage_warning_flag;
    logic             warning_interrupt_enable;
    logic             detect_reset_enable;
    logic             detect_stop_enable;
    logic             detect_enable;
    logic             bandgap_buffer_bit;

    // Control bundles towards the rest of the device
    sovm_pkg::sovm_sysctl_s sysctl;
    sovm_pkg::sovm_pwrctl_s pwrctl;

    // Monitor levels in the bus clock domain
    logic [1:0]       levels_sync;
    logic             warn_s;
    logic             detect_s;
    logic             warn_prev;
    logic             detect_prev;

    // Bus decode, one write strobe per register
    logic             wr_en;
    logic             rd_en;
    logic             hit;
    logic [7:0]       wbyte;
    logic             options_wr;
    logic             options_two_wr;
    logic             power_wr;
    logic             status_wr;
    logic             mask_wr;

    // Events and derived controls
    logic             warn_event;
    logic             detect_event;
    logic             detect_armed;
    logic             stop_blocked;
    logic [`SOVM_IRQ_BITS-1:0] irq_event;
    logic [`SOVM_IRQ_BITS-1:0] next_irq_status;
    logic [31:0]      next_prdata;

    localparam logic [7:0] power_reset_value = `SOVM_POWER_RESET;

    // Exact match on the whole byte address, so no register has an alias
    function automatic logic sel(input logic [11:0] addr, input logic [11:0] off);
        return addr == off;
    endfunction

    // Anything outside these five words answers with an error
    function automatic logic is_mapped(input logic [11:0] addr);
        return sel(addr, `SOVM_OFF_OPTIONS) || sel(addr, `SOVM_OFF_POWER) ||
               sel(addr, `SOVM_OFF_OPTIONS_TWO) || sel(addr, `SOVM_OFF_IRQ_STATUS) ||
               sel(addr, `SOVM_OFF_IRQ_MASK);
    endfunction

    // Every access finishes in its first access cycle
    assign pready  = 1'b1;
    assign hit     = is_mapped(paddr);
    assign wr_en   = psel && penable && pwrite && hit && pstrb[0];
    assign rd_en   = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !hit;
    assign wbyte   = pwdata[7:0];

    // Registers are one byte wide; the upper write lanes are ignored
    assign options_wr     = wr_en && sel(paddr, `SOVM_OFF_OPTIONS);
    assign options_two_wr = wr_en && sel(paddr, `SOVM_OFF_OPTIONS_TWO);
    assign power_wr       = wr_en && sel(paddr, `SOVM_OFF_POWER);
    assign status_wr      = wr_en && sel(paddr, `SOVM_OFF_IRQ_STATUS);
    assign mask_wr        = wr_en && sel(paddr, `SOVM_OFF_IRQ_MASK);

    // Monitor levels come from the analog side, asynchronous to the bus clock
    sovm_sync #(
        .WIDTH(2)
    ) sovm_sync_i (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({detect_level, warning_level}),
        .sync_out (levels_sync)
    );

    // Bit 0 carries the warning level, bit 1 the detect level
    assign warn_s   = levels_sync[0];
    assign detect_s = levels_sync[1];

    // Levels already high at reset release still give an event, since prev resets to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_prev   <= 1'b0;
            detect_prev <= 1'b0;
        end else begin
            warn_prev   <= warn_s;
            detect_prev <= detect_s;
        end
    end

    assign warn_event = warn_s && !warn_prev;

    // Detect is gated by enable and, in stop, by stop enable
    assign detect_armed = power[`SOVM_PWR_DE] && (!in_stop || power[`SOVM_PWR_DSE]);
    assign detect_event = detect_armed && detect_s && !detect_prev;

    // Options register: write-once; reserved bit stored but drives nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            options <= `SOVM_OPTIONS_RESET;
        end else if (options_wr && options_state == sovm_pkg::SOVM_WRITE_OPEN) begin
            options <= wbyte & `SOVM_OPTIONS_MASK;
        end
    end

    // Any write closes the register, even one repeating the reset settings,
    // so a stray write later cannot move the watchdog timeout or the stop permit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            options_state <= sovm_pkg::SOVM_WRITE_OPEN;
        end else if (options_wr) begin
            options_state <= sovm_pkg::SOVM_WRITE_LOCKED;
        end
    end

    // Watchdog clock select lives in the second options register, always writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            options_two <= `SOVM_OPTIONS_TWO_RST;
        end else if (options_two_wr) begin
            options_two <= wbyte & 8'h80;
        end
    end

    // Power controls that software may change at any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warning_interrupt_enable <= power_reset_value[`SOVM_PWR_WIE];
            detect_stop_enable       <= power_reset_value[`SOVM_PWR_DSE];
            bandgap_buffer_bit       <= power_reset_value[`SOVM_PWR_BANDGAP_BUFFER_ENABLE];
        end else if (power_wr) begin
            warning_interrupt_enable <= wbyte[`SOVM_PWR_WIE];
            detect_stop_enable       <= wbyte[`SOVM_PWR_DSE];
            bandgap_buffer_bit       <= wbyte[`SOVM_PWR_BANDGAP_BUFFER_ENABLE];
        end
    end

    // First power write fixes supervision, so a runaway program cannot drop it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detect_reset_enable <= power_reset_value[`SOVM_PWR_DRE];
            detect_enable       <= power_reset_value[`SOVM_PWR_DE];
            power_state         <= sovm_pkg::SOVM_WRITE_OPEN;
        end else if (power_wr && power_state == sovm_pkg::SOVM_WRITE_OPEN) begin
            detect_reset_enable <= wbyte[`SOVM_PWR_DRE];
            detect_enable       <= wbyte[`SOVM_PWR_DE];
            power_state         <= sovm_pkg::SOVM_WRITE_LOCKED;
        end
    end

    // Set wins over acknowledge; acknowledge fails while warning present
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_voltage_warning_flag <= power_reset_value[`SOVM_PWR_WFLAG];
        end else if (warn_event) begin
            low_voltage_warning_flag <= 1'b1;
        end else if (power_wr && wbyte[`SOVM_PWR_WACK] && !warn_s) begin
            low_voltage_warning_flag <= 1'b0;
        end
    end

    // Acknowledge is write-only and bit 1 is unused; both read as zero
    always_comb begin
        power                  = 8'h00;
        power[`SOVM_PWR_WFLAG] = low_voltage_warning_flag;
        power[`SOVM_PWR_WIE]   = warning_interrupt_enable;
        power[`SOVM_PWR_DRE]   = detect_reset_enable;
        power[`SOVM_PWR_DSE]   = detect_stop_enable;
        power[`SOVM_PWR_DE]    = detect_enable;
        power[`SOVM_PWR_BANDGAP_BUFFER_ENABLE]  = bandgap_buffer_bit;
    end

    // A stop without permit is refused and also recorded as a status event
    assign stop_blocked = stop_request && !options[`SOVM_OPT_STOP];

    assign irq_event[`SOVM_IRQ_WARN]    = warn_event;
    assign irq_event[`SOVM_IRQ_DETECT]  = detect_event;
    assign irq_event[`SOVM_IRQ_BLOCKED] = stop_blocked;

    // An event in the cycle of its clear keeps the bit, so none is ever lost
    for (genvar i = 0; i < `SOVM_IRQ_BITS; i++) begin : g_status
        assign next_irq_status[i] = irq_event[i] || (irq_status[i] && !(status_wr && wbyte[i]));
    end

    // Status bits take their next value every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Mask has the layout of the status register; a one lets the bit through
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (mask_wr) begin
            irq_mask <= wbyte[`SOVM_IRQ_BITS-1:0];
        end
    end

    // Read data registered in setup, stable through access phase
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (sel(paddr, `SOVM_OFF_OPTIONS)) begin
            next_prdata[7:0] = options;
        end else if (sel(paddr, `SOVM_OFF_POWER)) begin
            next_prdata[7:0] = power & `SOVM_POWER_MASK;
        end else if (sel(paddr, `SOVM_OFF_OPTIONS_TWO)) begin
            next_prdata[7:0] = options_two;
        end else if (sel(paddr, `SOVM_OFF_IRQ_STATUS)) begin
            next_prdata[`SOVM_IRQ_BITS-1:0] = irq_status;
        end else if (sel(paddr, `SOVM_OFF_IRQ_MASK)) begin
            next_prdata[`SOVM_IRQ_BITS-1:0] = irq_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= next_prdata;
        end
    end

    // System option bundle; reserved bit 4 is deliberately left out
    always_comb begin
        sysctl.timeout_select = options[`SOVM_OPT_WDT_HI:`SOVM_OPT_WDT_LO];
        sysctl.clock_select   = options_two[`SOVM_OPT2_WDTCLK];
        sysctl.stop_permit    = options[`SOVM_OPT_STOP];
        sysctl.pin_select     = options[`SOVM_OPT_PINSEL];
    end

    // Power control bundle
    always_comb begin
        pwrctl.detect_active  = detect_armed;
        pwrctl.detect_reset_req      = detect_event && power[`SOVM_PWR_DRE];
        pwrctl.bandgap_buffer_enable = power[`SOVM_PWR_BANDGAP_BUFFER_ENABLE];
        pwrctl.warning_irq    = power[`SOVM_PWR_WIE] && power[`SOVM_PWR_WFLAG];
    end

    // Stop outcome registered, exactly one of the two pulses follows a stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            illegal_op_reset <= 1'b0;
            stop_enter       <= 1'b0;
        end else begin
            illegal_op_reset <= stop_blocked;
            stop_enter       <= stop_request && sysctl.stop_permit;
        end
    end

    // Detect reset registered so it is glitch free; one cycle long since the
    // event is an edge, the reset controller stretches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detect_reset <= 1'b0;
        end else begin
            detect_reset <= pwrctl.detect_reset_req;
        end
    end

    // Register fields drive the rest of the device directly
    assign detect_on               = pwrctl.detect_active;
    assign bandgap_buffer_enable   = pwrctl.bandgap_buffer_enable;
    assign watchdog_timeout_select = sysctl.timeout_select;
    assign watchdog_clock_select   = sysctl.clock_select;
    assign two_wire_pin_select     = sysctl.pin_select;
    assign sda_on_port_a_pin_2     = !sysctl.pin_select;
    assign scl_on_port_a_pin_3     = !sysctl.pin_select;
    assign sda_on_port_b_pin_6     = sysctl.pin_select;
    assign scl_on_port_b_pin_7     = sysctl.pin_select;

    // Interrupt requests are levels, held until software clears the cause
    assign warning_irq             = pwrctl.warning_irq;
    assign irq                     = |(irq_status & irq_mask);

endmodule // sovm_regs

// File: tb/sovm_regs_asserts.sv
// Concurrent checks on the ports of the options and power monitor registers
`timescale 1ns/1ps
module sovm_regs_asserts (
    input wire logic        pclk,                    // Clock
    input wire logic        presetn,                 // Reset, low
    input wire logic        psel,                    // Select
    input wire logic        penable,                 // Access phase
    input wire logic        pwrite,                  // Write
    input wire logic [11:0] paddr,                   // Address
    input wire logic [3:0]  pstrb,                   // Strobes
    input wire logic        pready,                  // Ready
    input wire logic        pslverr,                 // Error
    input wire logic        stop_request,            // Stop executed
    input wire logic        stop_enter,              // Stop allowed
    input wire logic        illegal_op_reset,        // Stop refused
    input wire logic        detect_reset,            // Detect reset
    input wire logic        detect_on,               // Detect armed
    input wire logic [1:0]  watchdog_timeout_select, // Timeout
    input wire logic        two_wire_pin_select,     // Pin select
    input wire logic        sda_on_port_a_pin_2,     // Data on A
    input wire logic        sda_on_port_b_pin_6,     // Data on B
    input wire logic        warning_irq              // Warning request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic lock_a;
    logic lock_b;
    // Two stages so the locking write itself may still change the outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_a <= 1'h0;
            lock_b <= 1'h0;
        end else begin
            lock_a <= lock_a || (psel && penable && pwrite && pstrb[0] && paddr == 12'h000);
            lock_b <= lock_a;
        end
    end
    sequence s_stop;
        stop_request;
    endsequence
    sequence s_one_outcome;
        stop_enter != illegal_op_reset;
    endsequence
    a_stop_outcome: assert property (s_stop |=> s_one_outcome)
        else $error("stop request without exactly one outcome");
    a_stop_cause: assert property ((stop_enter || illegal_op_reset) |-> $past(stop_request))
        else $error("stop outcome without a request");
    a_options_frozen: assert property (lock_b |-> $stable(watchdog_timeout_select) && $stable(two_wire_pin_select))
        else $error("options changed after first write");
    a_pin_route: assert property (sda_on_port_a_pin_2 == !two_wire_pin_select && sda_on_port_b_pin_6 == two_wire_pin_select)
        else $error("two-wire routing wrong");
    a_warn_drop: assert property ($fell(warning_irq) |-> $past(psel && penable && pwrite))
        else $error("warning request dropped without a write");
    a_dreset_pulse: assert property (detect_reset |=> !detect_reset)
        else $error("detect reset longer than one cycle");
    a_dreset_gate: assert property (detect_reset |-> $past(detect_on))
        else $error("detect reset while detection off");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h010 |-> pready && pslverr)
        else $error("unmapped access not refused");
endmodule // sovm_regs_asserts

bind sovm_regs sovm_regs_asserts sovm_regs_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pstrb,
    .pready, .pslverr, .stop_request, .stop_enter, .illegal_op_reset, .detect_reset, .detect_on,
    .watchdog_timeout_select, .two_wire_pin_select, .sda_on_port_a_pin_2, .sda_on_port_b_pin_6, .warning_irq);

// File: tb/sovm_regs_tb.sv
// Self-checking bench for the options and power monitor registers
`timescale 1ns/1ps
`include "sovm_defs.svh"
module sovm_regs_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        warning_level, detect_level, stop_request, in_stop, stop_enter, illegal_op_reset;
    logic        detect_reset, detect_on, bandgap_buffer_enable, watchdog_clock_select, two_wire_pin_select;
    logic [1:0]  watchdog_timeout_select;
    logic        sda_on_port_a_pin_2, scl_on_port_a_pin_3, sda_on_port_b_pin_6, scl_on_port_b_pin_7;
    logic        warning_irq, irq;
    int          err_count = 0;
    int          checks = 0;
    int          n_det = 0;
    int          n_stop = 0;
    int          n_ill = 0;

    sovm_regs sovm_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .prdata, .pslverr, .warning_level, .detect_level, .stop_request, .in_stop, .stop_enter,
        .illegal_op_reset, .detect_reset, .detect_on, .bandgap_buffer_enable, .watchdog_timeout_select,
        .watchdog_clock_select, .two_wire_pin_select, .sda_on_port_a_pin_2, .scl_on_port_a_pin_3,
        .sda_on_port_b_pin_6, .scl_on_port_b_pin_7, .warning_irq, .irq);

    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    // Pulses are counted mid-cycle, away from the launching edge
    always @(negedge pclk) begin
        if (detect_reset === 1'h1) n_det++;
        if (stop_enter === 1'h1) n_stop++;
        if (illegal_op_reset === 1'h1) n_ill++;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            err_count++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rdc(input string what, input logic [11:0] a, input logic [7:0] exp);
        apb(1'h0, a, 8'h00);
        chk(what, {24'h000000, exp}, rd);
    endtask

    task automatic do_reset(input logic warn);
        presetn <= 1'h0;
        warning_level <= warn;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
    endtask

    task automatic stop_pulse();
        stop_request <= 1'h1;
        @(posedge pclk);
        stop_request <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic t_first();
        rdc("options reset", `SOVM_OFF_OPTIONS, 8'hD3);
        rdc("power reset", `SOVM_OFF_POWER, 8'h1C);
        rdc("unmapped", 12'h020, 8'h00);
        chk("unmapped error", 1, er);
        wr(`SOVM_OFF_OPTIONS, 8'h24);
        wr(`SOVM_OFF_OPTIONS, 8'hFF);
        rdc("options once", `SOVM_OFF_OPTIONS, 8'h24);
        chk("port b route", 2'h3, {sda_on_port_b_pin_6, scl_on_port_b_pin_7});
        chk("pin select", 1, two_wire_pin_select);
        stop_pulse();
        chk("stop entered", 1, n_stop);
        chk("no illegal", 0, n_ill);
        wr(`SOVM_OFF_POWER, 8'h25);
        chk("bandgap on", 1, bandgap_buffer_enable);
        chk("detect on", 1, detect_on);
        wr(`SOVM_OFF_IRQ_MASK, 8'h01);
        chk("irq idle", 0, {warning_irq, irq});
        warning_level <= 1'h1;
        repeat (5) @(posedge pclk);
        chk("warning raised", 2'h3, {warning_irq, irq});
        wr(`SOVM_OFF_POWER, 8'h65);
        rdc("ack refused", `SOVM_OFF_POWER, 8'hA5);
        warning_level <= 1'h0;
        repeat (5) @(posedge pclk);
        rdc("flag sticky", `SOVM_OFF_POWER, 8'hA5);
        wr(`SOVM_OFF_POWER, 8'h64);
        rdc("flag acked", `SOVM_OFF_POWER, 8'h24);
        chk("bandgap off", 0, bandgap_buffer_enable);
        chk("irq status held", 2'h1, {warning_irq, irq});
        wr(`SOVM_OFF_IRQ_STATUS, 8'h01);
        chk("irq cleared", 0, irq);
        detect_level <= 1'h1;
        repeat (6) @(posedge pclk);
        chk("no detect reset", 0, n_det);
        detect_level <= 1'h0;
    endtask

    task automatic t_second();
        repeat (4) @(posedge pclk);
        rdc("flag after reset", `SOVM_OFF_POWER, 8'h9C);
        wr(`SOVM_OFF_OPTIONS, 8'hD0);
        rdc("options again", `SOVM_OFF_OPTIONS, 8'hD0);
        chk("timeout select", 2'h3, watchdog_timeout_select);
        chk("port a route", 2'h3, {sda_on_port_a_pin_2, scl_on_port_a_pin_3});
        wr(`SOVM_OFF_OPTIONS_TWO, 8'h80);
        chk("clock select", 1, watchdog_clock_select);
        stop_pulse();
        chk("stop refused", 16'h0101, {n_stop[7:0], n_ill[7:0]});
        wr(`SOVM_OFF_POWER, 8'h1C);
        chk("polled only", 0, warning_irq);
        in_stop <= 1'h1;
        @(posedge pclk);
        chk("stop detect on", 1, detect_on);
        detect_level <= 1'h1;
        repeat (6) @(posedge pclk);
        chk("detect reset", 1, n_det);
        wr(`SOVM_OFF_POWER, 8'h14);
        chk("stop detect off", 0, detect_on);
        wr(`SOVM_OFF_POWER, 8'h00);
        rdc("locked bits", `SOVM_OFF_POWER, 8'h94);
    endtask

    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite, warning_level, detect_level, stop_request, in_stop} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        do_reset(1'h0);
        t_first();
        do_reset(1'h1);
        t_second();
        print_verdict();
    end
endmodule // sovm_regs_tb
